// ==== inc/irq_mask_regs.svh ====
// register offsets, field positions and reset values of the interrupt enable mask
`ifndef IRQ_MASK_REGS_SVH
`define IRQ_MASK_REGS_SVH

`define MASK_SET_OFS 8'h88
`define MASK_CLR_OFS 8'h8C
`define MASK_RESET 32'h0000_0000
`define MASK_WRITABLE 32'hEFFF_83FF
`define MASK_RSVD_HI 28
`define MASK_RSVD_LO_TOP 14
`define MASK_RSVD_LO_BOT 10
`define GLOBAL_GATE_BIT 31
`define MAKER_EVENT_BIT 30
`define SOFT_EVENT_BIT 29
`define ISO_RX_BIT 7
`define ISO_TX_BIT 6
`define SELF_ID_BIT 16
`define SELF_ID2_BIT 15
`define BUS_REINIT_BIT 17
`define ISO_TX_CTX 8
`define ISO_RX_CTX 4
`define ADDR_W 8

`endif

// ==== inc/irq_mask_pkg.sv ====
// types shared by the interrupt enable mask block
package irq_mask_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apb_rsp_s;

	typedef struct packed {
		logic [7:0] tx_event;
		logic [7:0] tx_enable;
		logic [3:0] rx_event;
		logic [3:0] rx_enable;
	} iso_ctx_s;
endpackage

// ==== hdl/link_interrupt_enable_mask.sv ====
// interrupt enable mask with set and clear aliases and interrupt gating
`timescale 1ns/1ps
`default_nettype none
`include "irq_mask_regs.svh"

// Behaviour
// - mask readable at set and clear alias
// - set alias sets, clear alias clears
// - global gate off blocks every interrupt
// - other bits gate event at same position
// - bit 30 gates maker added event
// - bit 29 gates software raised event
// - bit 28 reserved, reads zero
// - bits 14 to 10 reserved, read zero
// - bits 27,26 gate late ack, line register
// - bits 25..23 gate cycle and fatal events
// - bits 22..20 gate missed, rollover, cycle start
// - bits 19,18 gate line status, failed access
// - bits 17..15 gate reinit and id done
// - bits 9,8 gate atomic and buffered errors
// - bits 7,6 gate iso summaries
// - bits 5,4 gate packet received events
// - bits 3,2 gate async receive dma
// - bits 1,0 gate send done events
// - iso summaries are unlatched or of contexts
// - id done cleared when reinit sets
module link_interrupt_enable_mask (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire irq_mask_pkg::apb_req_s apb_req,
	output irq_mask_pkg::apb_rsp_s apb_rsp,
	// latched events from the event register
	input wire logic [31:0] event_bits,
	// per context iso events and enables
	input wire irq_mask_pkg::iso_ctx_s iso_ctx,
	// hardware clear of the global gate
	input wire logic gate_hw_clear,
	// hardware side event view and interrupt
	output logic node_id_phase_done_clear,
	output logic [31:0] masked_events,
	output logic irq_out
);
	import irq_mask_pkg::*;

	// ****************************************
	// register state
	// ****************************************
	logic [31:0] mask_r;
	logic [31:0] mask_nxt;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic irq_r;
	logic reinit_prev_r;
	logic [31:0] events_eff;
	logic iso_tx_summary;
	logic iso_rx_summary;
	logic wr_set;
	logic wr_clr;
	logic hit;
	logic access;

	assign access = apb_req.psel && apb_req.penable;
	assign hit = (apb_req.paddr == `MASK_SET_OFS) || (apb_req.paddr == `MASK_CLR_OFS);
	assign wr_set = access && apb_req.pwrite && (apb_req.paddr == `MASK_SET_OFS);
	assign wr_clr = access && apb_req.pwrite && (apb_req.paddr == `MASK_CLR_OFS);

	// ****************************************
	// mask update
	// ****************************************
	always_comb begin
		mask_nxt = mask_r;
		if (wr_set) begin
			mask_nxt = mask_r | (apb_req.pwdata & `MASK_WRITABLE);
		end
		if (wr_clr) begin
			mask_nxt = mask_r & ~(apb_req.pwdata & `MASK_WRITABLE);
		end
		if (gate_hw_clear) begin
			mask_nxt[`GLOBAL_GATE_BIT] = 1'b0;
		end
		mask_nxt[`MASK_RSVD_HI] = 1'b0;
		mask_nxt[`MASK_RSVD_LO_TOP:`MASK_RSVD_LO_BOT] = '0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_r <= `MASK_RESET;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// ****************************************
	// apb read path
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= `MASK_RESET;
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= 1'b0;
			if (apb_req.psel && !apb_req.penable) begin
				prdata_r <= hit ? mask_r : 32'h0000_0000;
				pslverr_r <= !hit;
			end
		end
	end

	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.prdata = prdata_r;
	assign apb_rsp.pslverr = pslverr_r && access;

	// ****************************************
	// event gating
	// ****************************************
	assign iso_tx_summary = |(iso_ctx.tx_event & iso_ctx.tx_enable);
	assign iso_rx_summary = |(iso_ctx.rx_event & iso_ctx.rx_enable);

	always_comb begin
		events_eff = event_bits;
		events_eff[`ISO_TX_BIT] = iso_tx_summary;
		events_eff[`ISO_RX_BIT] = iso_rx_summary;
		events_eff[`GLOBAL_GATE_BIT] = 1'b0;
	end

	// per position gating over bits 30..0
	genvar g;
	generate
		for (g = 0; g < 31; g++) begin : gate_g
			assign masked_events[g] = mask_r[g] & events_eff[g];
		end
	endgenerate
	assign masked_events[31] = 1'b0;

	// id done cleared on rising edge of reinit event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reinit_prev_r <= 1'b0;
		end else begin
			reinit_prev_r <= event_bits[`BUS_REINIT_BIT];
		end
	end
	assign node_id_phase_done_clear = event_bits[`BUS_REINIT_BIT] && !reinit_prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= mask_r[`GLOBAL_GATE_BIT] && (|masked_events);
		end
	end
	assign irq_out = irq_r;

	// ****************************************
	// assertions
	// ****************************************
	sequence set_write_s;
		wr_set && apb_req.pwdata[0] && !wr_clr;
	endsequence

	gate_blocks_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		!mask_r[`GLOBAL_GATE_BIT] |=> !irq_out)
		else $error("irq raised with global gate off");
	irq_follows_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_out == $past(mask_r[31] && (|(mask_r[30:0] & events_eff[30:0]))))
		else $error("irq does not match masked events");
	set_alias_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
		set_write_s |=> mask_r[0])
		else $error("set alias failed to set bit");
	clr_alias_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clr && apb_req.pwdata[5] |=> !mask_r[5])
		else $error("clear alias failed to clear bit");
	zero_bits_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_set && !apb_req.pwdata[3] && !gate_hw_clear |=> mask_r[3] == $past(mask_r[3]))
		else $error("zero write bit changed mask");
	rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		mask_r[28] == 1'b0 && mask_r[14:10] == 5'h0)
		else $error("reserved mask bit nonzero");
	read_alias_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_req.psel && !apb_req.penable && hit && !apb_req.pwrite |=> prdata_r == $past(mask_r))
		else $error("read alias returned wrong data");
	iso_summary_a: assert property (@(posedge pclk) disable iff (!presetn)
		masked_events[6] == (mask_r[6] && |(iso_ctx.tx_event & iso_ctx.tx_enable)))
		else $error("iso transmit summary wrong");
	id_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(event_bits[17]) |-> node_id_phase_done_clear)
		else $error("id done not cleared on reinit");
endmodule
`default_nettype wire

// ==== tb/link_interrupt_enable_mask_tb.sv ====
// self-checking bench for the interrupt enable mask
`timescale 1ns/1ps
`default_nettype none
`include "irq_mask_regs.svh"
module link_interrupt_enable_mask_tb;
	import irq_mask_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	apb_req_s req = '0;
	apb_rsp_s rsp;
	logic [31:0] ev = '0;
	iso_ctx_s iso = '0;
	logic hw_clr = 0;
	logic id_clr;
	logic [31:0] masked;
	logic irq;
	int mismatches = 0;
	int tests_run = 0;
	logic [31:0] q, m, e, x;
	logic err;
	logic [31:0] rows [5][2] = '{'{32'hFFFF_FFFF, 32'hFFFF_FFFF}, '{32'h7FFF_FFFF, 32'hFFFF_FFFF},
		'{32'h8000_0001, 32'h0000_0001}, '{32'hA000_0000, 32'h4000_0000},
		'{32'hC000_0000, 32'h4000_0000}};
	link_interrupt_enable_mask i_link_interrupt_enable_mask (.pclk(pclk), .presetn(presetn),
		.apb_req(req), .apb_rsp(rsp), .event_bits(ev), .iso_ctx(iso), .gate_hw_clear(hw_clr),
		.node_id_phase_done_clear(id_clr), .masked_events(masked), .irq_out(irq));
	initial begin
		forever #5 pclk = ~pclk;
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, x, s);
		end
	endtask
	// ****************************************
	// apb transfer, waits for pready
	// ****************************************
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		req.psel <= 1;
		req.penable <= 0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) mismatches++;
		q = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 0;
		req.penable <= 0;
	endtask
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		mismatches++;
		test_done;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(0, `MASK_SET_OFS, 0);
		chk("reset mask", q, 32'h0000_0000);
		chk("reset irq", {31'h0, irq}, 32'h0000_0000);
		foreach (rows[i]) begin
			m = rows[i][0];
			e = rows[i][1];
			x = m & e & 32'h6FFF_833F;
			apb(1, `MASK_CLR_OFS, 32'hFFFF_FFFF);
			apb(1, `MASK_SET_OFS, m);
			ev <= e;
			apb(0, `MASK_SET_OFS, 0);
			chk("set alias read", q, m & 32'hEFFF_83FF);
			apb(0, `MASK_CLR_OFS, 0);
			chk("clear alias read", q, m & 32'hEFFF_83FF);
			chk("masked events", masked, x);
			chk("irq", {31'h0, irq}, {31'h0, m[31] & |x});
		end
		apb(1, `MASK_SET_OFS, 32'hFFFF_FFFF);
		apb(1, `MASK_CLR_OFS, 32'h0000_0001);
		apb(0, `MASK_CLR_OFS, 0);
		chk("partial clear", q, 32'hEFFF_83FE);
		ev <= 0;
		iso.tx_event <= 8'h04;
		iso.tx_enable <= 8'h04;
		repeat (2) @(posedge pclk);
		chk("iso tx summary", masked, 32'h0000_0040);
		chk("iso irq", {31'h0, irq}, 32'h0000_0001);
		iso <= '{tx_event: 8'h04, tx_enable: 8'h00, rx_event: 4'h8, rx_enable: 4'h8};
		repeat (2) @(posedge pclk);
		chk("iso rx summary", masked, 32'h0000_0080);
		iso <= '0;
		repeat (2) @(posedge pclk);
		chk("iso unlatched", masked, 32'h0000_0000);
		hw_clr <= 1;
		@(posedge pclk);
		hw_clr <= 0;
		apb(0, `MASK_SET_OFS, 0);
		chk("hw gate clear", q, 32'h6FFF_83FE);
		apb(0, 8'h80, 0);
		chk("unmapped data", q, 32'h0000_0000);
		chk("unmapped err", {31'h0, err}, 32'h0000_0001);
		ev <= 32'h0002_0000;
		@(negedge pclk);
		chk("id done clear", {31'h0, id_clr}, 32'h0000_0001);
		@(negedge pclk);
		chk("id done pulse end", {31'h0, id_clr}, 32'h0000_0000);
		test_done;
	end
endmodule
`default_nettype wire
